//--- include/boot_cfg_params.svh
// Constants of the boot configuration loader: word offsets, field
// positions, reset values and self-test timing.
// Assumes a 50 MHz core clock and the three configuration words held here.
//
// Notes on behaviour
// - Bit 20 low runs memory self-test each boot; not copied to working copy.
// - Memory self-test lasts about 100 us; first angle waits for it.
// - Bits 19:18 set minimum function pulse 9..12 ticks, protocol 7 only.
// - Bits 17:16 set where the slot counter wraps to zero.
// - Slot codes mean one to four sensors; all share the same code.
// - Own slot number comes from the two slot address pins.
// - Bit 23 of diag_enables_and_filter_num_three lets a diagnostic pulse start Hall self-test.
// - Bit 22 low runs 36 ms Hall self-test each boot before angles.
// - Bit 21 low runs 4.5 ms ROM checksum each boot before angles.
// - Bit 20 of diag_enables_and_filter_num_three high validates CRC on serial input; default ignore.
// - Harmonic maximum above 13 reuses CRC bit as harmonic phase seed.
// - Bits 19:16 seed harmonic maximum copy and coefficient reassignment.
// - Bits 15:0 of each word seed the working filter coefficients.
// - Watchdog fault sets both halt and timeout flags.
// - Recovery off: only report the fault; host resets the part.
// - Recovery on: report, then soft reset without reloading words.
// - Lock bit set refuses every later nonvolatile write until reset reloads the words.
// - Recovery and lock settings readable by command 0xfff8 after init.
`ifndef BOOT_CFG_PARAMS_SVH
`define BOOT_CFG_PARAMS_SVH

`define NV_ADDR_SHARE 12'h308
`define NV_ADDR_DIAG 12'h309
`define NV_ADDR_FAULT 12'h30a
`define NV_RST_SHARE 24'h000156
`define NV_RST_DIAG 24'h4000ab
`define NV_RST_FAULT 24'h00ec39

`define BIT_MEM_DIS 20
`define BIT_ADJ_HI 19
`define BIT_ADJ_LO 18
`define BIT_SLOT_HI 17
`define BIT_SLOT_LO 16
`define BIT_DIAG_EN 23
`define BIT_HALL_DIS 22
`define BIT_ROM_DIS 21
`define BIT_CRC_EN 20
`define BIT_HAR_HI 19
`define BIT_HAR_LO 16
`define BIT_FR 23
`define BIT_LOCK 22
`define BIT_COEF_HI 15

`define MIN_PULSE_TICKS 4'h9
`define LONG_SHARED_MODE 3'h7
`define HAR_PHASE_LIMIT 4'hd
`define EXT_CMD_LOCKS 16'hfff8

`define CLK_PERIOD_NS 20
`define MEM_BIST_NS 100000
`define ROM_CHECK_NS 4500000
`define HALL_TEST_NS 36000000
`define MEM_BIST_CYC (`MEM_BIST_NS / `CLK_PERIOD_NS)
`define ROM_CHECK_CYC (`ROM_CHECK_NS / `CLK_PERIOD_NS)
`define HALL_TEST_CYC (`HALL_TEST_NS / `CLK_PERIOD_NS)

`endif

//--- include/boot_cfg_pkg.sv
// Types shared by the boot configuration loader.
// Assumes boot_cfg_params.svh carries all numeric constants.
package boot_cfg_pkg;
    typedef enum logic [2:0] {
        ST_LOAD,
        ST_APPLY,
        ST_MEM,
        ST_ROM,
        ST_HALL,
        ST_RUN
    } boot_state_type;
    typedef logic [20:0] test_count_type;
endpackage : boot_cfg_pkg

//--- verilog/selftest_timer.sv
// Down counter that times one self-test.
// Assumes the start pulse arrives only while idle.
`timescale 1ns/1ps
module selftest_timer (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input boot_cfg_pkg::test_count_type i_cycles,
    output logic o_busy,
    output logic o_done
);
    import boot_cfg_pkg::*;
    test_count_type count_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                count_reg <= i_cycles;
                o_busy <= 1'b1;
            end else if (o_busy) begin
                count_reg <= count_reg - 21'h1;
                if (count_reg <= 21'h1) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end
endmodule : selftest_timer

//--- verilog/boot_selftest_and_fault_config.sv
// Boot configuration loader: nonvolatile words, self-test sequencing,
// shared output bus settings, watchdog fault handling.
// Assumes host ports are synchronous to the core clock.
`timescale 1ns/1ps
`include "boot_cfg_params.svh"
module boot_selftest_and_fault_config #(
    parameter logic [20:0] MEM_BIST_CYCLES = 21'(`MEM_BIST_CYC),
    parameter logic [20:0] ROM_CHECK_CYCLES = 21'(`ROM_CHECK_CYC),
    parameter logic [20:0] HALL_TEST_CYCLES = 21'(`HALL_TEST_CYC)
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_nv_wr,
    input wire logic i_nv_rd,
    input wire logic [11:0] i_nv_addr,
    input wire logic [23:0] i_nv_wdata,
    input wire logic i_ext_rd,
    input wire logic [15:0] i_ext_cmd,
    input wire logic i_slot_address_pin_zero,
    input wire logic i_slot_address_pin_one,
    input wire logic [2:0] i_output_protocol_select,
    input wire logic i_slot_advance,
    input wire logic i_diag_pulse,
    input wire logic i_wdog_fault,
    input wire logic i_extended_error_register_clear,
    output boot_cfg_pkg::boot_state_type o_boot_state,
    output logic o_angle_enable,
    output logic o_nv_wr_ack,
    output logic o_nv_wr_refused,
    output logic o_nv_rvalid,
    output logic [23:0] o_nv_rdata,
    output logic o_ext_valid,
    output logic o_ext_err,
    output logic [15:0] o_ext_rdata,
    output logic [3:0] o_min_func_pulse_ticks,
    output logic [1:0] o_slot_count,
    output logic o_slot_active,
    output logic o_spi_crc_check_enable,
    output logic o_harmonic_phase_coeff,
    output logic [3:0] o_harmonic_max_working_copy,
    output logic o_coeff_reassign,
    output logic [15:0] o_filter_num_two_working,
    output logic [15:0] o_filter_num_three_working,
    output logic [15:0] o_filter_den_two_working,
    output logic o_watchdog_halt_flag,
    output logic o_watchdog_timeout_flag,
    output logic o_soft_reset,
    output logic o_hall_test_busy
);
    import boot_cfg_pkg::*;

    // ------------------------------------------------------------
    // Decoding and test order
    // ------------------------------------------------------------
    function automatic logic [2:0] word_sel(input logic [11:0] addr);
        word_sel = 3'h0;
        case (addr)
            `NV_ADDR_SHARE: word_sel = 3'h4;
            `NV_ADDR_DIAG: word_sel = 3'h5;
            `NV_ADDR_FAULT: word_sel = 3'h6;
            default: word_sel = 3'h0;
        endcase
    endfunction : word_sel

    function automatic boot_state_type pick_after(input boot_state_type st,
            input logic mem_dis, input logic rom_dis, input logic hall_dis);
        pick_after = ST_RUN;
        if (st == ST_APPLY && !mem_dis) begin
            pick_after = ST_MEM;
        end else if (st != ST_ROM && !rom_dis) begin
            pick_after = ST_ROM;
        end else if (!hall_dis) begin
            pick_after = ST_HALL;
        end
    endfunction : pick_after

    // ------------------------------------------------------------
    // Nonvolatile words
    // ------------------------------------------------------------
    logic [23:0] nv_mem [0:2];
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;
    logic nv_locked;
    assign wr_sel = word_sel(i_nv_addr);
    assign rd_sel = word_sel(i_nv_addr);
    assign nv_locked = nv_mem[2][`BIT_LOCK];

    // Lock is read live so a lock write takes hold at once
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nv_mem[0] <= `NV_RST_SHARE;
            nv_mem[1] <= `NV_RST_DIAG;
            nv_mem[2] <= `NV_RST_FAULT;
            o_nv_wr_ack <= 1'b0;
            o_nv_wr_refused <= 1'b0;
        end else begin
            o_nv_wr_ack <= 1'b0;
            o_nv_wr_refused <= 1'b0;
            if (i_nv_wr) begin
                if (nv_locked || !wr_sel[2]) begin
                    o_nv_wr_refused <= 1'b1;
                end else begin
                    nv_mem[wr_sel[1:0]] <= i_nv_wdata;
                    o_nv_wr_ack <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_nv_rvalid <= 1'b0;
            o_nv_rdata <= '0;
        end else begin
            o_nv_rvalid <= i_nv_rd;
            if (i_nv_rd) begin
                o_nv_rdata <= rd_sel[2] ? nv_mem[rd_sel[1:0]] : 24'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------
    boot_state_type state_reg;
    boot_state_type state_next;
    logic mem_dis_reg, rom_dis_reg, hall_dis_reg, diag_en_reg;
    logic fr_reg, lock_reg;
    logic [1:0] adj_reg, max_slot_reg, own_slot_reg;
    logic tmr_start, tmr_busy, tmr_done;
    test_count_type tmr_cycles;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_LOAD: state_next = ST_APPLY;
            ST_APPLY: state_next = pick_after(ST_APPLY, mem_dis_reg,
                rom_dis_reg, hall_dis_reg);
            ST_MEM: if (tmr_done) begin
                state_next = pick_after(ST_MEM, 1'b1, rom_dis_reg,
                    hall_dis_reg);
            end
            ST_ROM: if (tmr_done) begin
                state_next = pick_after(ST_ROM, 1'b1, 1'b1,
                    hall_dis_reg);
            end
            ST_HALL: if (tmr_done) begin
                state_next = ST_RUN;
            end
            ST_RUN: if (i_diag_pulse && diag_en_reg) begin
                state_next = ST_HALL;
            end
            default: state_next = ST_LOAD;
        endcase
    end

    always_comb begin
        tmr_start = (state_next != state_reg) && (state_next == ST_MEM ||
            state_next == ST_ROM || state_next == ST_HALL);
        case (state_next)
            ST_MEM: tmr_cycles = MEM_BIST_CYCLES;
            ST_ROM: tmr_cycles = ROM_CHECK_CYCLES;
            default: tmr_cycles = HALL_TEST_CYCLES;
        endcase
    end

    selftest_timer u_timer (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_start(tmr_start),
        .i_cycles(tmr_cycles),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_LOAD;
            o_angle_enable <= 1'b0;
            o_hall_test_busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_angle_enable <= (state_next == ST_RUN);
            o_hall_test_busy <= (state_next == ST_HALL);
        end
    end
    assign o_boot_state = state_reg;

    // ------------------------------------------------------------
    // Configuration applied once per boot
    // ------------------------------------------------------------
    // Soft reset after a watchdog fault does not pass here again
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {mem_dis_reg, rom_dis_reg, hall_dis_reg, diag_en_reg} <= '0;
            {fr_reg, lock_reg, adj_reg, max_slot_reg, own_slot_reg} <= '0;
            o_spi_crc_check_enable <= 1'b0;
            o_harmonic_phase_coeff <= 1'b0;
            o_harmonic_max_working_copy <= '0;
            o_coeff_reassign <= 1'b0;
            o_filter_num_two_working <= '0;
            o_filter_num_three_working <= '0;
            o_filter_den_two_working <= '0;
        end else if (state_reg == ST_LOAD) begin
            mem_dis_reg <= nv_mem[0][`BIT_MEM_DIS];
            adj_reg <= nv_mem[0][`BIT_ADJ_HI:`BIT_ADJ_LO];
            max_slot_reg <= nv_mem[0][`BIT_SLOT_HI:`BIT_SLOT_LO];
            own_slot_reg <= {i_slot_address_pin_one,
                i_slot_address_pin_zero};
            diag_en_reg <= nv_mem[1][`BIT_DIAG_EN];
            hall_dis_reg <= nv_mem[1][`BIT_HALL_DIS];
            rom_dis_reg <= nv_mem[1][`BIT_ROM_DIS];
            fr_reg <= nv_mem[2][`BIT_FR];
            lock_reg <= nv_mem[2][`BIT_LOCK];
            // Above the phase limit the CRC bit becomes a phase seed
            if (nv_mem[1][`BIT_HAR_HI:`BIT_HAR_LO] > `HAR_PHASE_LIMIT) begin
                o_spi_crc_check_enable <= 1'b0;
                o_harmonic_phase_coeff <= nv_mem[1][`BIT_CRC_EN];
            end else begin
                o_spi_crc_check_enable <= nv_mem[1][`BIT_CRC_EN];
                o_harmonic_phase_coeff <= 1'b0;
            end
            o_harmonic_max_working_copy <=
                nv_mem[1][`BIT_HAR_HI:`BIT_HAR_LO];
            o_coeff_reassign <=
                |nv_mem[1][`BIT_HAR_HI:`BIT_HAR_LO];
            o_filter_num_two_working <= nv_mem[0][`BIT_COEF_HI:0];
            o_filter_num_three_working <= nv_mem[1][`BIT_COEF_HI:0];
            o_filter_den_two_working <= nv_mem[2][`BIT_COEF_HI:0];
        end
    end

    // ------------------------------------------------------------
    // Shared output bus slotting
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_slot_count <= '0;
            o_slot_active <= 1'b0;
            o_min_func_pulse_ticks <= `MIN_PULSE_TICKS;
        end else begin
            if (state_reg == ST_RUN && i_slot_advance) begin
                o_slot_count <= (o_slot_count >= max_slot_reg) ? 2'h0 :
                    o_slot_count + 2'h1;
            end
            o_slot_active <= (state_reg == ST_RUN) &&
                (o_slot_count == own_slot_reg);
            if (i_output_protocol_select == `LONG_SHARED_MODE) begin
                o_min_func_pulse_ticks <= `MIN_PULSE_TICKS +
                    {2'h0, adj_reg};
            end else begin
                o_min_func_pulse_ticks <= `MIN_PULSE_TICKS;
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog faults and the lock readback command
    // ------------------------------------------------------------
    // A fault in the clearing cycle keeps the flags set
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_watchdog_halt_flag <= 1'b0;
            o_watchdog_timeout_flag <= 1'b0;
            o_soft_reset <= 1'b0;
        end else begin
            if (i_wdog_fault) begin
                o_watchdog_halt_flag <= 1'b1;
                o_watchdog_timeout_flag <= 1'b1;
            end else if (i_extended_error_register_clear) begin
                o_watchdog_halt_flag <= 1'b0;
                o_watchdog_timeout_flag <= 1'b0;
            end
            o_soft_reset <= i_wdog_fault && fr_reg;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ext_valid <= 1'b0;
            o_ext_err <= 1'b0;
            o_ext_rdata <= '0;
        end else begin
            o_ext_valid <= 1'b0;
            o_ext_err <= 1'b0;
            if (i_ext_rd) begin
                if (i_ext_cmd == `EXT_CMD_LOCKS &&
                        state_reg != ST_LOAD) begin
                    o_ext_valid <= 1'b1;
                    o_ext_rdata <= {14'h0, fr_reg, lock_reg};
                end else begin
                    o_ext_err <= 1'b1;
                    o_ext_rdata <= '0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_bist_skip_mem: assert property (
        state_reg == ST_APPLY && mem_dis_reg |=> state_reg != ST_MEM)
        else $error("memory test ran while disabled");
    a_bist_hold_angle: assert property (
        state_reg == ST_MEM |-> !o_angle_enable)
        else $error("angle enabled during memory test");
    a_pulse_min_ticks: assert property (
        i_output_protocol_select == 3'h7 && $stable(adj_reg)
        |=> o_min_func_pulse_ticks == 4'h9 + {2'h0, adj_reg})
        else $error("function pulse threshold wrong");
    a_slot_wrap_zero: assert property (
        state_reg == ST_RUN && i_slot_advance &&
        o_slot_count == max_slot_reg |=> o_slot_count == 2'h0)
        else $error("slot counter did not wrap");
    a_diag_gate_off: assert property (
        state_reg == ST_RUN && i_diag_pulse && !diag_en_reg
        |=> state_reg == ST_RUN)
        else $error("diagnostic pulse started test while disabled");
    a_rom_test_len: assert property (
        state_reg != ST_ROM ##1 state_reg == ST_ROM
        |-> state_reg == ST_ROM [*2])
        else $error("ROM test ended too early");
    a_crc_phase_split: assert property (
        state_reg == ST_LOAD && nv_mem[1][19:16] > 4'hd
        |=> !o_spi_crc_check_enable)
        else $error("CRC check kept above phase limit");
    a_wdog_both_flags: assert property (
        i_wdog_fault |=> o_watchdog_halt_flag && o_watchdog_timeout_flag)
        else $error("watchdog flags not both set");
    a_soft_reset_mode: assert property (
        i_wdog_fault |=> o_soft_reset == $past(fr_reg) &&
        state_reg != ST_LOAD)
        else $error("soft reset does not follow recovery mode");
    a_lock_refuse_wr: assert property (
        i_nv_wr && nv_locked |=> o_nv_wr_refused && !o_nv_wr_ack &&
        $stable(nv_mem[2]))
        else $error("write accepted while locked");
    a_ext_lock_read: assert property (
        i_ext_rd && i_ext_cmd == 16'hfff8 && state_reg != ST_LOAD
        |=> o_ext_valid && o_ext_rdata[1:0] == $past({fr_reg, lock_reg}))
        else $error("lock readback wrong");
    a_angle_after_tests: assert property (
        $rose(o_angle_enable) |-> !tmr_busy)
        else $error("angle started while a test runs");

    c_full_boot: cover property (
        state_reg == ST_HALL ##1 state_reg == ST_RUN);
    c_diag_hall: cover property (
        state_reg == ST_RUN && i_diag_pulse && diag_en_reg);
    c_locked_write: cover property (i_nv_wr && nv_locked);
    c_soft_reset: cover property (o_soft_reset);
endmodule : boot_selftest_and_fault_config

//--- tb/host_model.sv
// Host model: issues nonvolatile and extended-command requests.
// Assumes the device answers within three cycles of a request.
`timescale 1ns/1ps
module host_model (
    input wire logic i_core_clk,
    input wire logic i_nv_wr_ack,
    input wire logic i_nv_wr_refused,
    input wire logic i_nv_rvalid,
    input wire logic [23:0] i_nv_rdata,
    input wire logic i_ext_valid,
    input wire logic i_ext_err,
    output logic o_nv_wr,
    output logic o_nv_rd,
    output logic [11:0] o_nv_addr,
    output logic [23:0] o_nv_wdata,
    output logic o_ext_rd,
    output logic [15:0] o_ext_cmd
);
    initial begin
        o_nv_wr = 1'b0;
        o_nv_rd = 1'b0;
        o_nv_addr = 12'h000;
        o_nv_wdata = 24'h000000;
        o_ext_rd = 1'b0;
        o_ext_cmd = 16'h0000;
    end
    // Bounded wait, so a silent device cannot hang the host
    task automatic wait_answer();
        int n;
        for (n = 0; n < 3; n++) begin
            if (i_nv_wr_ack | i_nv_wr_refused | i_nv_rvalid
                | i_ext_valid | i_ext_err) break;
            @(negedge i_core_clk);
        end
    endtask : wait_answer
    // Every sensor on one bus gets one pulse adjust and slot code
    task automatic nv_write(input logic [11:0] a, input logic [23:0] d);
        @(negedge i_core_clk);
        o_nv_addr = a;
        o_nv_wdata = d;
        o_nv_wr = 1'b1;
        @(negedge i_core_clk);
        o_nv_wr = 1'b0;
        o_nv_wdata = ~d;
        wait_answer();
    endtask : nv_write
    task automatic nv_read(input logic [11:0] a);
        @(negedge i_core_clk);
        o_nv_addr = a;
        o_nv_rd = 1'b1;
        @(negedge i_core_clk);
        o_nv_rd = 1'b0;
        wait_answer();
    endtask : nv_read
    task automatic ext_read(input logic [15:0] c);
        @(negedge i_core_clk);
        o_ext_cmd = c;
        o_ext_rd = 1'b1;
        @(negedge i_core_clk);
        o_ext_rd = 1'b0;
        wait_answer();
    endtask : ext_read
endmodule : host_model

//--- tb/boot_selftest_and_fault_config_tb.sv
// Testbench of the boot configuration loader.
// Assumes shortened self-test counts of 8, 12 and 16 cycles.
`timescale 1ns/1ps
module boot_selftest_and_fault_config_tb;
    import boot_cfg_pkg::*;
    logic i_core_clk, i_rst_n, pin0, pin1;
    logic adv, diag, wdog, xclr;
    logic [2:0] proto;
    logic nv_wr, nv_rd, ext_rd, ang, wack, wref, rv, ev, ee;
    logic [11:0] nv_addr;
    logic [23:0] nv_wdata, rdata;
    logic [15:0] ext_cmd, erd, fn2, fn3, fd2;
    logic [3:0] mpt, hmax;
    logic [1:0] scnt;
    logic sact, crc, hph, reas, hf, tf, srst, hbusy;
    boot_state_type st;
    int err_total = 0, checks_done = 0, cyc_count = 0;
    always #10 i_core_clk = ~i_core_clk;
    boot_selftest_and_fault_config #(.MEM_BIST_CYCLES(21'h8),
        .ROM_CHECK_CYCLES(21'hc), .HALL_TEST_CYCLES(21'h10))
    boot_selftest_and_fault_config_inst (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_nv_wr(nv_wr), .i_nv_rd(nv_rd),
        .i_nv_addr(nv_addr), .i_nv_wdata(nv_wdata), .i_ext_rd(ext_rd),
        .i_ext_cmd(ext_cmd), .i_slot_address_pin_zero(pin0),
        .i_slot_address_pin_one(pin1), .i_output_protocol_select(proto),
        .i_slot_advance(adv), .i_diag_pulse(diag), .i_wdog_fault(wdog),
        .i_extended_error_register_clear(xclr), .o_boot_state(st), .o_angle_enable(ang),
        .o_nv_wr_ack(wack), .o_nv_wr_refused(wref), .o_nv_rvalid(rv),
        .o_nv_rdata(rdata), .o_ext_valid(ev), .o_ext_err(ee),
        .o_ext_rdata(erd), .o_min_func_pulse_ticks(mpt),
        .o_slot_count(scnt), .o_slot_active(sact),
        .o_spi_crc_check_enable(crc), .o_harmonic_phase_coeff(hph),
        .o_harmonic_max_working_copy(hmax), .o_coeff_reassign(reas),
        .o_filter_num_two_working(fn2), .o_filter_num_three_working(fn3),
        .o_filter_den_two_working(fd2), .o_watchdog_halt_flag(hf),
        .o_watchdog_timeout_flag(tf), .o_soft_reset(srst),
        .o_hall_test_busy(hbusy));
    host_model host_model_inst (.i_core_clk(i_core_clk),
        .i_nv_wr_ack(wack), .i_nv_wr_refused(wref), .i_nv_rvalid(rv),
        .i_nv_rdata(rdata), .i_ext_valid(ev), .i_ext_err(ee),
        .o_nv_wr(nv_wr), .o_nv_rd(nv_rd), .o_nv_addr(nv_addr),
        .o_nv_wdata(nv_wdata), .o_ext_rd(ext_rd), .o_ext_cmd(ext_cmd));
    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] e,
                         input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // Boots take about 30 cycles; 4000 leaves ample margin
    always @(posedge i_core_clk) begin
        cyc_count++;
        if (cyc_count == 4000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic do_boot(output int n, output boot_state_type s4,
                           output boot_state_type s15);
        i_rst_n = 1'b0;
        repeat (5) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        n = 0;
        while (ang !== 1'b1 && n < 200) begin
            @(negedge i_core_clk);
            n++;
            if (n == 4) s4 = st;
            if (n == 15) s15 = st;
        end
    endtask : do_boot
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_boot();
        int n;
        boot_state_type s4, s15;
        do_boot(n, s4, s15);
        check("memory test", 24'(ST_MEM), 24'(s4));
        check("rom check", 24'(ST_ROM), 24'(s15));
        // Two setup cycles, then each enabled test lasts its count plus one
        check("cycles to run", 24'h000018, 24'(n));
        check("hall busy", 24'h0, 24'(hbusy));
        check("num two", 24'h000156, 24'(fn2));
        check("num three", 24'h0000ab, 24'(fn3));
        check("den two", 24'h00ec39, 24'(fd2));
        check("crc enable", 24'h0, 24'(crc));
        check("harmonic", 24'h0, {reas, hph, hmax});
        check("pulse ticks", 24'h9, 24'(mpt));
    endtask : test_boot
    task automatic test_regs();
        host_model_inst.nv_read(12'h308);
        check("read 308", 24'h000156, rdata);
        host_model_inst.nv_read(12'h309);
        check("read 309", 24'h4000ab, rdata);
        host_model_inst.nv_read(12'h30a);
        check("read 30a", 24'h00ec39, rdata);
        host_model_inst.nv_read(12'h300);
        check("read unmapped", 24'h0, rdata);
        host_model_inst.nv_write(12'h300, 24'h123456);
        check("unmapped write", 24'h1, 24'(wref));
    endtask : test_regs
    task automatic test_ext();
        host_model_inst.ext_read(16'hfff8);
        check("ext valid", 24'h1, 24'(ev));
        check("ext data", 24'h0, 24'(erd));
        host_model_inst.ext_read(16'hfff0);
        check("ext err", 24'h1, 24'(ee));
    endtask : test_ext
    task automatic test_wdog();
        int n;
        boot_state_type a, b;
        @(negedge i_core_clk);
        wdog = 1'b1;
        @(negedge i_core_clk);
        wdog = 1'b0;
        check("wdog flags", 24'h3, {hf, tf});
        check("soft reset", 24'h0, 24'(srst));
        check("angle kept", 24'h1, 24'(ang));
        xclr = 1'b1;
        @(negedge i_core_clk);
        xclr = 1'b0;
        @(negedge i_core_clk);
        check("flags cleared", 24'h0, {hf, tf});
        wdog = 1'b1;
        xclr = 1'b1;
        @(negedge i_core_clk);
        wdog = 1'b0;
        xclr = 1'b0;
        check("fault beats clear", 24'h3, {hf, tf});
        do_boot(n, a, b); // Host resets the part after the fault
        check("reboot", 24'h000018, 24'(n));
    endtask : test_wdog
    task automatic test_diag_slot();
        int n;
        boot_state_type a, b;
        @(negedge i_core_clk);
        diag = 1'b1;
        @(negedge i_core_clk);
        diag = 1'b0;
        @(negedge i_core_clk);
        check("diag ignored", 24'h1, {hbusy, ang});
        repeat (3) begin
            adv = 1'b1;
            @(negedge i_core_clk);
            adv = 1'b0;
            @(negedge i_core_clk);
            check("slot count", 24'h0, 24'(scnt));
            check("slot active", 24'h1, 24'(sact));
        end
        // Pins are sampled only at boot, so reboot with slot three
        pin0 = 1'b1;
        pin1 = 1'b1;
        proto = 3'h0;
        do_boot(n, a, b);
        repeat (2) @(negedge i_core_clk);
        check("pulse ticks other mode", 24'h9, 24'(mpt));
        check("other slot idle", 24'h0, 24'(sact));
        proto = 3'h7;
    endtask : test_diag_slot
    task automatic test_lock();
        host_model_inst.nv_write(12'h308, 24'h000aaa);
        check("write ack", 24'h1, 24'(wack));
        host_model_inst.nv_write(12'h30a, 24'h40ec39);
        check("lock ack", 24'h1, 24'(wack));
        host_model_inst.nv_write(12'h308, 24'h000555);
        check("locked write", 24'h1, 24'(wref));
        host_model_inst.nv_read(12'h308);
        check("word kept", 24'h000aaa, rdata);
    endtask : test_lock
    initial begin
        i_core_clk = 1'b0;
        i_rst_n = 1'b0;
        pin0 = 1'b0;
        pin1 = 1'b0;
        adv = 1'b0;
        diag = 1'b0;
        wdog = 1'b0;
        xclr = 1'b0;
        proto = 3'h7;
        test_boot();
        test_regs();
        test_ext();
        test_wdog();
        test_diag_slot();
        test_lock();
        print_verdict();
    end
endmodule : boot_selftest_and_fault_config_tb
